// >>> design/crc_col_buf.sv
`timescale 1ns/100ps
`default_nettype none

module crc_col_buf (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic col_valid,
    input wire logic [crc_pkg::COL_W-1:0] col_data,
    input wire logic col_take,
    output logic buf_valid,
    output logic [crc_pkg::COL_W-1:0] buf_data,
    output logic overrun
);

    typedef struct packed {
        logic valid;
        logic [crc_pkg::COL_W-1:0] data;
        logic ovr;
    } crc_buf_t;

    crc_buf_t s_q;
    crc_buf_t s_d;

    // ==========================================================
    // One-column holding register
    always_comb
    begin
        s_d = s_q;
        s_d.ovr = 1'b0;
        if (col_take)
        begin
            s_d.valid = 1'b0;
        end
        // A new column always overwrites; an old one not taken in the same cycle is lost and flagged
        if (col_valid)
        begin
            s_d.ovr = s_q.valid & ~col_take;
            s_d.valid = 1'b1;
            s_d.data = col_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign buf_valid = s_q.valid;
    assign buf_data = s_q.data;
    assign overrun = s_q.ovr;

endmodule : crc_col_buf

`default_nettype wire

// >>> design/crc_irq.sv
`timescale 1ns/100ps
`default_nettype none

module crc_irq (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [crc_pkg::IRQ_N-1:0] events,
    input wire logic [crc_pkg::IRQ_N-1:0] clear_bits,
    input wire logic mask_wr,
    input wire logic [crc_pkg::IRQ_N-1:0] mask_data,
    input wire logic int_en,
    output logic [crc_pkg::IRQ_N-1:0] sticky,
    output logic [crc_pkg::IRQ_N-1:0] mask,
    output logic irq
);

    typedef struct packed {
        logic [crc_pkg::IRQ_N-1:0] sts;
        logic [crc_pkg::IRQ_N-1:0] msk;
    } crc_irq_t;

    crc_irq_t s_q;
    crc_irq_t s_d;
    logic [crc_pkg::IRQ_N-1:0] sts_next;

    // ==========================================================
    // Sticky bits: an event in the clearing cycle survives
    genvar i;
    generate
        for (i = 0; i < crc_pkg::IRQ_N; i++)
        begin : g_bit
            assign sts_next[i] = events[i] | (s_q.sts[i] & ~clear_bits[i]);
        end
    endgenerate

    always_comb
    begin
        s_d = s_q;
        s_d.sts = sts_next;
        if (mask_wr)
        begin
            s_d.msk = mask_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q.sts <= '0;
            s_q.msk <= crc_pkg::IRQ_MASK_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign sticky = s_q.sts;
    assign mask = s_q.msk;
    assign irq = int_en & (|(s_q.sts & s_q.msk));

endmodule : crc_irq

`default_nettype wire

// >>> design/crc_pkg.sv
package crc_pkg;

    // ==========================================================
    // Bus and register map
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam logic [7:0] OFS_STATUS_CMD = 8'h04;
    localparam logic [7:0] OFS_COLUMN = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFS_CONTROL = 8'h14;

    // ==========================================================
    // Status byte fields
    localparam int unsigned ST_OVERRUN = 0;
    localparam int unsigned ST_TROUBLE = 1;
    localparam int unsigned ST_HOPPER = 2;
    localparam int unsigned ST_NO_MOTION = 3;
    localparam int unsigned ST_AWAITING = 4;
    localparam int unsigned ST_EXCEPTION = 5;
    localparam int unsigned ST_EOM = 6;
    localparam int unsigned ST_UNAVAIL = 7;

    // ==========================================================
    // Command byte fields
    localparam int unsigned CMD_DISABLE = 0;
    localparam int unsigned CMD_ENABLE = 1;
    localparam int unsigned CMD_FEED = 2;

    // ==========================================================
    // Column data and interrupt events
    localparam int unsigned COL_W = 12;
    localparam int unsigned IRQ_N = 2;
    localparam int unsigned EV_COLUMN = 0;
    localparam int unsigned EV_EXCEPTION = 1;
    localparam logic [IRQ_N-1:0] IRQ_MASK_RESET = 2'h0;
    localparam logic RESET_INT_EN = 1'b0;
    localparam logic RESET_EOM = 1'b1;

    typedef enum logic [0:0] {
        CRC_IDLE = 1'b0,
        CRC_MOVING = 1'b1
    } crc_state_t;

endpackage : crc_pkg

// >>> design/crc_top.sv
`timescale 1ns/100ps
`default_nettype none

module crc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [crc_pkg::ADDR_W-1:0] paddr,
    input wire logic [crc_pkg::DATA_W-1:0] pwdata,
    output logic [crc_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rdr_col_valid,
    input wire logic [crc_pkg::COL_W-1:0] rdr_col_data,
    input wire logic rdr_card_done,
    input wire logic rdr_last_card,
    input wire logic rdr_pick_fail,
    input wire logic rdr_motion_err,
    input wire logic rdr_light_err,
    input wire logic rdr_dark_err,
    input wire logic operator_reset,
    output logic rdr_feed,
    output logic irq
);

    typedef struct packed {
        crc_pkg::crc_state_t state;
        logic trouble;
        logic unavail;
        logic hopper;
        logic overrun;
        logic end_of_motion;
        logic int_en;
        logic feed;
        logic exc_prev;
        logic col_prev;
        logic [crc_pkg::DATA_W-1:0] rdata;
        logic err;
    } crc_top_t;

    crc_top_t s_q;
    crc_top_t s_d;

    logic setup;
    logic access;
    logic wr_acc;
    logic [7:0] status;
    logic [7:0] cmd;
    logic buf_valid;
    logic [crc_pkg::COL_W-1:0] buf_data;
    logic buf_ovr;
    logic col_take;
    logic fault;
    logic feed_ok;
    logic no_motion;
    logic exception;
    logic [crc_pkg::IRQ_N-1:0] irq_events;
    logic [crc_pkg::IRQ_N-1:0] irq_clear;
    logic [crc_pkg::IRQ_N-1:0] irq_sticky;
    logic [crc_pkg::IRQ_N-1:0] irq_mask;
    logic mask_wr;

    // ==========================================================
    // APB decode: zero wait states, read data latched in setup
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr_acc = access & pwrite;
    assign pready = access;
    assign cmd = pwdata[7:0];

    assign col_take = access & ~pwrite & (paddr == crc_pkg::OFS_COLUMN);
    assign mask_wr = wr_acc & (paddr == crc_pkg::OFS_IRQ_MASK);
    assign irq_clear = (wr_acc && paddr == crc_pkg::OFS_IRQ_STATUS) ?
        pwdata[crc_pkg::IRQ_N-1:0] : '0;

    // ==========================================================
    // Status byte
    assign no_motion = (s_q.state == crc_pkg::CRC_IDLE);
    assign exception = s_q.overrun | s_q.trouble | s_q.hopper | no_motion;

    always_comb
    begin
        status = 8'h00;
        status[crc_pkg::ST_OVERRUN] = s_q.overrun;
        status[crc_pkg::ST_TROUBLE] = s_q.trouble;
        status[crc_pkg::ST_HOPPER] = s_q.hopper;
        status[crc_pkg::ST_NO_MOTION] = no_motion;
        status[crc_pkg::ST_AWAITING] = ~no_motion & ~buf_valid;
        status[crc_pkg::ST_EXCEPTION] = exception;
        status[crc_pkg::ST_EOM] = s_q.end_of_motion;
        status[crc_pkg::ST_UNAVAIL] = s_q.unavail;
    end

    // ==========================================================
    // Reader faults and feed gating
    assign fault = rdr_pick_fail | rdr_motion_err | rdr_light_err | rdr_dark_err;
    assign feed_ok = ~(s_q.trouble | s_q.unavail | s_q.hopper);

    assign irq_events[crc_pkg::EV_COLUMN] = buf_valid & ~s_q.col_prev;
    assign irq_events[crc_pkg::EV_EXCEPTION] = exception & ~s_q.exc_prev;

    always_comb
    begin
        s_d = s_q;
        s_d.feed = 1'b0;
        s_d.exc_prev = exception;
        s_d.col_prev = buf_valid;
        s_d.err = 1'b0;

        // Read data and error answer are prepared in the setup cycle
        if (setup)
        begin
            s_d.rdata = '0;
            if (paddr == crc_pkg::OFS_STATUS_CMD)
            begin
                s_d.rdata[7:0] = pwrite ? 8'h00 : status;
            end
            else if (paddr == crc_pkg::OFS_COLUMN)
            begin
                s_d.rdata[crc_pkg::COL_W-1:0] = buf_data;
                s_d.err = pwrite;
            end
            else if (paddr == crc_pkg::OFS_IRQ_STATUS)
            begin
                s_d.rdata[crc_pkg::IRQ_N-1:0] = irq_sticky;
            end
            else if (paddr == crc_pkg::OFS_IRQ_MASK)
            begin
                s_d.rdata[crc_pkg::IRQ_N-1:0] = irq_mask;
            end
            else if (paddr == crc_pkg::OFS_CONTROL)
            begin
                s_d.rdata[0] = s_q.int_en;
            end
            else
            begin
                s_d.err = 1'b1;
            end
        end
        else if (access)
        begin
            s_d.err = s_q.err;
        end

        // Operator reset first so a simultaneous fault still sets
        if (operator_reset)
        begin
            s_d.trouble = 1'b0;
            s_d.unavail = 1'b0;
            s_d.hopper = 1'b0;
        end

        // Command byte
        if (wr_acc && paddr == crc_pkg::OFS_STATUS_CMD)
        begin
            if (cmd[crc_pkg::CMD_DISABLE])
            begin
                s_d.int_en = 1'b0;
            end
            if (cmd[crc_pkg::CMD_ENABLE])
            begin
                s_d.int_en = 1'b1;
            end
            // A fault seen the same cycle blocks the feed as well
            if (cmd[crc_pkg::CMD_FEED] && feed_ok && !fault && !rdr_last_card)
            begin
                s_d.state = crc_pkg::CRC_MOVING;
                s_d.feed = 1'b1;
                s_d.overrun = 1'b0;
                s_d.end_of_motion = 1'b0;
            end
        end

        // Mechanism events
        case (s_q.state)
            crc_pkg::CRC_IDLE:
            begin
            end
            crc_pkg::CRC_MOVING:
            begin
                if (rdr_card_done || fault || rdr_last_card)
                begin
                    s_d.state = crc_pkg::CRC_IDLE;
                    s_d.end_of_motion = 1'b1;
                end
            end
            default:
            begin
                s_d.state = crc_pkg::CRC_IDLE;
            end
        endcase

        if (rdr_last_card)
        begin
            s_d.hopper = 1'b1;
            s_d.state = crc_pkg::CRC_IDLE;
            s_d.end_of_motion = 1'b1;
        end
        if (fault)
        begin
            s_d.trouble = 1'b1;
            s_d.unavail = 1'b1;
            s_d.state = crc_pkg::CRC_IDLE;
        end
        if (buf_ovr)
        begin
            s_d.overrun = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
            s_q.state <= crc_pkg::CRC_IDLE;
            s_q.end_of_motion <= crc_pkg::RESET_EOM;
            s_q.int_en <= crc_pkg::RESET_INT_EN;
            s_q.exc_prev <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdata;
    assign pslverr = access & s_q.err;
    assign rdr_feed = s_q.feed;

    // ==========================================================
    // Column holding register and interrupt unit
    crc_col_buf u_col_buf (
        .pclk(pclk),
        .presetn(presetn),
        .col_valid(rdr_col_valid),
        .col_data(rdr_col_data),
        .col_take(col_take),
        .buf_valid(buf_valid),
        .buf_data(buf_data),
        .overrun(buf_ovr)
    );

    crc_irq u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .events(irq_events),
        .clear_bits(irq_clear),
        .mask_wr(mask_wr),
        .mask_data(pwdata[crc_pkg::IRQ_N-1:0]),
        .int_en(s_q.int_en),
        .sticky(irq_sticky),
        .mask(irq_mask),
        .irq(irq)
    );

endmodule : crc_top

`default_nettype wire

// >>> verification/crc_reader_model.sv
`timescale 1ns/100ps
`default_nettype none

module crc_reader_model (
    input wire logic pclk,
    input wire logic feed,
    input wire logic [7:0] gap,
    input wire logic [2:0] ncol,
    input wire logic last,
    input wire logic [11:0] base,
    output logic col_valid,
    output logic [11:0] col_data,
    output logic card_done,
    output logic last_card
);
    // ====================
    // Card transport, columns spaced by gap cycles
    initial
    begin
        col_valid = 1'b0;
        col_data = 12'hFFF;
        card_done = 1'b0;
        last_card = 1'b0;
    end

    always
    begin
        @(posedge pclk);
        if (feed === 1'b1)
        begin
            for (int i = 0; i < ncol; i++)
            begin
                repeat (gap) @(posedge pclk);
                col_valid <= 1'b1;
                col_data <= base + 12'(i);
                @(posedge pclk);
                col_valid <= 1'b0;
                // Idle lines invert so stale data never looks valid
                col_data <= ~(base + 12'(i));
            end
            repeat (gap) @(posedge pclk);
            card_done <= 1'b1;
            last_card <= last;
            @(posedge pclk);
            card_done <= 1'b0;
            last_card <= 1'b0;
        end
    end
endmodule : crc_reader_model

`default_nettype wire

// >>> verification/crc_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module crc_top_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [crc_pkg::ADDR_W-1:0] paddr,
    input wire logic [crc_pkg::DATA_W-1:0] pwdata,
    input wire logic [crc_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic rdr_last_card,
    input wire logic rdr_pick_fail,
    input wire logic rdr_motion_err,
    input wire logic rdr_light_err,
    input wire logic rdr_dark_err,
    input wire logic operator_reset,
    input wire logic rdr_feed,
    input wire logic irq
);
    // ====================
    // Helper state
    logic blk_q;
    logic rd_st;
    logic wr_cmd;
    assign rd_st = psel && penable && !pwrite && paddr == crc_pkg::OFS_STATUS_CMD;
    assign wr_cmd = psel && penable && pwrite && paddr == crc_pkg::OFS_STATUS_CMD;
    // A fault or an empty hopper stays until the operator clears it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            blk_q <= 1'b0;
        else if (rdr_pick_fail | rdr_motion_err | rdr_light_err | rdr_dark_err | rdr_last_card)
            blk_q <= 1'b1;
        else if (operator_reset)
            blk_q <= 1'b0;
    end
    // ====================
    // Properties
    default clocking mon_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_ready; pready == (psel && penable); endproperty
    a_ready: assert property (p_ready) else $error("pready wrong");
    property p_feed_len; rdr_feed |=> !rdr_feed; endproperty
    a_feed_len: assert property (p_feed_len) else $error("feed too long");
    property p_feed_src; rdr_feed |-> $past(wr_cmd && pwdata[2]); endproperty
    a_feed_src: assert property (p_feed_src) else $error("feed without command");
    property p_feed_blk; blk_q |-> !rdr_feed; endproperty
    a_feed_blk: assert property (p_feed_blk) else $error("feed while blocked");
    property p_ex; rd_st |-> prdata[5] == (|prdata[3:0]); endproperty
    a_ex: assert property (p_ex) else $error("exception wrong");
    property p_hop; rd_st && prdata[2] |-> prdata[3]; endproperty
    a_hop: assert property (p_hop) else $error("hopper without no motion");
    property p_eom; rd_st && prdata[3] |-> prdata[6]; endproperty
    a_eom: assert property (p_eom) else $error("no motion without end");
    property p_dis; wr_cmd && pwdata[1:0] == 2'b01 |=> !irq; endproperty
    a_dis: assert property (p_dis) else $error("irq after disable");
endmodule : crc_top_monitor

bind crc_top crc_top_monitor crc_top_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .rdr_last_card, .rdr_pick_fail, .rdr_motion_err,
    .rdr_light_err, .rdr_dark_err, .operator_reset, .rdr_feed, .irq);

`default_nettype wire

// >>> verification/test_card_reader_controller.sv
`timescale 1ns/100ps
`default_nettype none

module test_card_reader_controller;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, operator_reset, last, perr;
    logic pready, pslverr, irq, feed, cval, cdone, clast;
    logic [7:0] paddr, gap;
    logic [31:0] pwdata, prdata, rdat;
    logic [2:0] ncol;
    logic [3:0] flt;
    logic [11:0] base, cdat, prev;
    int seed, bad_count, compares, feeds, old;

    always #25 pclk = ~pclk;

    always @(posedge pclk)
        if (feed === 1'b1)
            feeds <= feeds + 1;

    crc_top crc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rdr_col_valid(cval), .rdr_col_data(cdat), .rdr_card_done(cdone),
        .rdr_last_card(clast), .rdr_pick_fail(flt[0]), .rdr_motion_err(flt[1]),
        .rdr_light_err(flt[2]), .rdr_dark_err(flt[3]), .operator_reset, .rdr_feed(feed), .irq);

    crc_reader_model crc_reader_model_inst (.pclk, .feed, .gap, .ncol, .last, .base,
        .col_valid(cval), .col_data(cdat), .card_done(cdone), .last_card(clast));

    // ====================
    // Checks and bus tasks
    function automatic logic [31:0] st(input logic [5:0] f);
        return {24'h0, f[4], f[0], |f[5:2], f[1], f[2], f[3], f[4], f[5]};
    endfunction : st

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            bad_count++;
            $display("FAIL at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rdat = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask : rd

    task automatic chk_irq(input logic e);
        @(negedge pclk);
        chk({31'h0, irq}, {31'h0, e});
        @(posedge pclk);
    endtask : chk_irq

    task automatic wait_irq;
        for (int n = 0; n < 400 && irq !== 1'b1; n++)
            @(negedge pclk);
        @(posedge pclk);
    endtask : wait_irq

    task automatic wait_idle;
        rdat = 32'h0;
        for (int n = 0; n < 100 && rdat[3] !== 1'b1; n++)
            apb(1'b0, 8'h04, 32'h0);
    endtask : wait_idle

    task automatic feed_card(input logic [2:0] n, input logic [7:0] g, input logic l);
        ncol <= n;
        gap <= g;
        last <= l;
        base <= 12'($random(seed));
        apb(1'b1, 8'h04, ($random(seed) & 32'hFFFF_FFF8) | 32'h4);
    endtask : feed_card

    task automatic pulse_op;
        operator_reset <= 1'b1;
        @(posedge pclk);
        operator_reset <= 1'b0;
        @(posedge pclk);
    endtask : pulse_op

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    // ====================
    // Sequence; watchdog allows some seventy times the expected run
    initial
    begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        conclude();
    end

    initial
    begin
        {presetn, psel, penable, pwrite, operator_reset, last} = 6'h00;
        {paddr, pwdata, flt, ncol, gap, base} = '0;
        {seed, bad_count, compares, feeds} = {32'd86697, 96'd0};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(8'h04, st(6'b000101));
        rd(8'h14, 32'h0);
        rd(8'h10, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, perr}, 32'h1);
        apb(1'b1, 8'h08, 32'h0);
        chk({31'h0, perr}, 32'h1);
        $display("test reset done");
        apb(1'b1, 8'h10, 32'h1);
        apb(1'b1, 8'h04, 32'h3);
        rd(8'h14, 32'h1);
        apb(1'b1, 8'h04, 32'h1);
        rd(8'h14, 32'h0);
        apb(1'b1, 8'h04, 32'h2);
        rd(8'h14, 32'h1);
        feed_card(3'(($random(seed) & 3) + 1), 8'(14 + ($random(seed) & 7)), 1'b0);
        rd(8'h04, st(6'b000010));
        for (int i = 0; i < ncol; i++)
        begin
            wait_irq();
            rd(8'h04, st(6'b000000));
            rd(8'h08, {20'h0, base + 12'(i)});
            apb(1'b1, 8'h0C, 32'h1);
        end
        wait_idle();
        rd(8'h04, st(6'b000101));
        $display("test column stream done");
        feed_card(3'h2, 8'h02, 1'b0);
        wait_idle();
        chk(rdat, st(6'b100101));
        prev = base + 12'h1;
        feed_card(3'h1, 8'd20, 1'b0);
        rd(8'h04, st(6'b000000));
        rd(8'h08, {20'h0, prev});
        wait_idle();
        chk_irq(1'b1);
        apb(1'b1, 8'h04, 32'h1);
        chk_irq(1'b0);
        rd(8'h14, 32'h0);
        rd(8'h08, {20'h0, base});
        apb(1'b1, 8'h0C, 32'h3);
        $display("test overrun done");
        feed_card(3'h1, 8'h04, 1'b1);
        wait_idle();
        chk(rdat, st(6'b001101));
        old = feeds;
        apb(1'b1, 8'h04, 32'h4);
        rd(8'h04, st(6'b001101));
        chk(feeds, old);
        pulse_op();
        rd(8'h04, st(6'b000101));
        $display("test hopper done");
        for (int k = 0; k < 4; k++)
        begin
            flt <= 4'h1 << k;
            @(posedge pclk);
            flt <= 4'h0;
            @(posedge pclk);
            rd(8'h04, st(6'b010101));
            old = feeds;
            apb(1'b1, 8'h04, 32'h4);
            pulse_op();
            chk(feeds, old);
            rd(8'h04, st(6'b000101));
        end
        $display("test faults done");
        conclude();
    end
endmodule : test_card_reader_controller

`default_nettype wire
